// ---- core/mpr_pkg.sv ----
// Constants and types shared by the multiplier result path
package mpr_pkg;
  // Operation kind, chosen by where the first operand was written
  typedef enum logic [1:0] {
    MPR_UMUL = 2'b00,
    MPR_SMUL = 2'b01,
    MPR_UACC = 2'b10,
    MPR_SACC = 2'b11
  } mpr_kind_t;

  // Read view selects
  localparam logic [2:0] MPR_SEL_W0 = 3'h0;
  localparam logic [2:0] MPR_SEL_W1 = 3'h1;
  localparam logic [2:0] MPR_SEL_W2 = 3'h2;
  localparam logic [2:0] MPR_SEL_W3 = 3'h3;
  localparam logic [2:0] MPR_SEL_CLO = 3'h4;
  localparam logic [2:0] MPR_SEL_CHI = 3'h5;
  localparam logic [2:0] MPR_SEL_SUM_EXTENSION_WORD = 3'h6;

  // Field positions
  localparam int MPR_SIGN32 = 31;
  localparam int MPR_SIGN64 = 63;
  localparam int MPR_BYTE_SIGN = 7;
  localparam int MPR_CARRY_SLOT = 4;

  // Reset values and extension word fills
  localparam logic [63:0] MPR_RESULT_RST = 64'h0;
  localparam logic [15:0] MPR_WORD_RST = 16'h0;
  localparam logic [3:0] MPR_CNT_RST = 4'hf;
  localparam logic [15:0] MPR_SUM_EXTENSION_WORD_ONES = 16'hffff;
  localparam logic [15:0] MPR_SUM_EXTENSION_WORD_ZERO = 16'h0000;

  // Ready cycles {carry, word3, word2, word1, word0}
  typedef logic [4:0][3:0] mpr_lat_t;
  localparam mpr_lat_t MPR_LAT_N_N = {4'h3, 4'h4, 4'h4, 4'h3, 4'h3};
  localparam mpr_lat_t MPR_LAT_W_N = {4'h7, 4'h7, 4'h6, 4'h5, 4'h3};
  localparam mpr_lat_t MPR_LAT_N_WL = {4'h7, 4'h7, 4'h6, 4'h5, 4'h3};
  localparam mpr_lat_t MPR_LAT_N_WH = {4'h4, 4'h4, 4'h4, 4'h3, 4'h0};
  localparam mpr_lat_t MPR_LAT_W_WL = {4'hb, 4'hb, 4'ha, 4'h8, 4'h3};
  localparam mpr_lat_t MPR_LAT_W_WH = {4'h6, 4'h6, 4'h5, 4'h3, 4'h0};
endpackage

// ---- core/mpr_res_if.sv ----
// Result bundle passed from the arithmetic core to its read-side helpers
`timescale 1ns/1ps
interface mpr_res_if;
  import mpr_pkg::*;
  logic [63:0] result;
  logic carry;
  mpr_kind_t kind;
  logic wide;
  logic frac;
  modport core (output result, output carry, output kind, output wide, output frac);
  modport view (input result, input carry, input kind, input wide, input frac);
endinterface

// ---- core/mpr_ext_unit.sv ----
// Sum-extension word derivation
`timescale 1ns/1ps
module mpr_ext_unit
  import mpr_pkg::*;
(
  // Result bundle
  mpr_res_if.view rif,
  // Derived word
  output logic [15:0] sum_extension_word
);
  logic sign_bit;
  logic two_lo;
  logic two_hi;

  // Sign from 32-bit or 64-bit result
  assign sign_bit = rif.wide ? rif.result[MPR_SIGN64] : rif.result[MPR_SIGN32];
  // Bits of the shifted result above the word boundary
  assign two_lo = sign_bit;
  assign two_hi = rif.carry;

  // Per-kind word value
  always_comb begin
    case (rif.kind)
      MPR_UMUL: sum_extension_word = MPR_SUM_EXTENSION_WORD_ZERO;
      MPR_UACC: sum_extension_word = {15'h0, rif.carry};
      MPR_SMUL, MPR_SACC: begin
        if (rif.frac) begin
          sum_extension_word = {{14{two_hi}}, two_hi, two_lo};
        end else begin
          sum_extension_word = sign_bit ? MPR_SUM_EXTENSION_WORD_ONES : MPR_SUM_EXTENSION_WORD_ZERO;
        end
      end
      default: sum_extension_word = MPR_SUM_EXTENSION_WORD_ZERO;
    endcase
  end
endmodule

// ---- core/mpr_read_view.sv ----
// Registered software read port with fractional shift
`timescale 1ns/1ps
module mpr_read_view
  import mpr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Result bundle
  mpr_res_if.view rif,
  input wire logic [15:0] sum_extension_word,
  // Read request
  input wire logic rd_en,
  input wire logic [2:0] rd_sel,
  output logic [15:0] rd_data
);
  typedef struct packed {
    logic [15:0] data;
  } mpr_rv_state_t;

  mpr_rv_state_t s_q;
  mpr_rv_state_t s_d;
  logic [64:0] view;

  // Shifted or plain view, store untouched
  assign view = rif.frac ? {rif.result, 1'b0} : {1'b0, rif.result};

  // Select word on a read
  always_comb begin
    s_d = s_q;
    if (rd_en) begin
      case (rd_sel)
        MPR_SEL_W0, MPR_SEL_CLO: s_d.data = view[15:0];
        MPR_SEL_W1, MPR_SEL_CHI: s_d.data = view[31:16];
        MPR_SEL_W2: s_d.data = view[47:32];
        MPR_SEL_W3: s_d.data = view[63:48];
        MPR_SEL_SUM_EXTENSION_WORD: s_d.data = sum_extension_word;
        default: s_d.data = MPR_WORD_RST;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.data;

  // Checks
  a_frac_word_read: assert property (@(posedge core_clk) disable iff (reset)
    rd_en && rif.frac && rd_sel == MPR_SEL_W1 |=> rd_data == $past(rif.result[30:15]))
    else $error("fractional word read not shifted");
  a_uacc_sum_extension_word: assert property (@(posedge core_clk) disable iff (reset)
    rd_en && rd_sel == MPR_SEL_SUM_EXTENSION_WORD && rif.kind == MPR_UACC
      |=> rd_data == {15'h0, $past(rif.carry)})
    else $error("unsigned accumulate extension word wrong");
endmodule

// ---- core/mpr_result_path.sv ----
// Multiplier result path: operands, result store, carry, ready timing
`timescale 1ns/1ps
module mpr_result_path
  import mpr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // First operand writes
  input wire logic first_wr,
  input wire logic [1:0] first_kind,
  input wire logic first_high,
  input wire logic first_byte,
  input wire logic [15:0] first_data,
  // Second operand writes
  input wire logic op2_16_wr,
  input wire logic op2_low_wr,
  input wire logic op2_high_wr,
  input wire logic op2_byte,
  input wire logic [15:0] op2_data,
  // Result preload
  input wire logic res_wr,
  input wire logic [1:0] res_wr_sel,
  input wire logic [15:0] res_wr_data,
  // Control
  input wire logic fractional_enable,
  // Software read
  input wire logic rd_en,
  input wire logic [2:0] rd_sel,
  output logic [15:0] rd_data,
  // Status
  output logic [3:0] result_word_valid,
  output logic carry_valid,
  output logic carry_flag
);
  typedef struct packed {
    logic [15:0] op1_lo;
    logic [15:0] op1_hi;
    logic op1_wide;
    mpr_kind_t kind;
    logic [15:0] op2_lo;
    logic [15:0] op2_hi;
    logic op2_wide;
    logic hi_pending;
    logic hi_done;
    logic calc;
    logic [63:0] base;
    logic [63:0] result;
    logic carry;
    logic [3:0] cnt_lo;
    logic [3:0] cnt_hi;
  } mpr_state_t;

  mpr_state_t s_q;
  mpr_state_t s_d;
  mpr_res_if rif ();

  logic is_signed;
  logic is_acc;
  logic [15:0] first_ext;
  logic [15:0] op2_ext;
  logic [31:0] op1_val;
  logic [31:0] op2_val;
  logic signed [32:0] op1_s;
  logic signed [32:0] op2_s;
  logic signed [65:0] prod_full;
  logic [63:0] prod;
  logic [32:0] sum32;
  logic [64:0] sum64;
  logic [63:0] calc_res;
  logic calc_carry;
  mpr_lat_t lat_lo;
  mpr_lat_t lat_hi;
  logic [4:0] ready;
  logic [15:0] sum_extension_word;

  ////////////////////////////////////////////////////////////////////
  // Operand shaping

  // Kind decode from stored first operand address
  assign is_signed = (s_q.kind == MPR_SMUL) || (s_q.kind == MPR_SACC);
  assign is_acc = (s_q.kind == MPR_UACC) || (s_q.kind == MPR_SACC);

  // Byte writes, sign-extended when the kind is signed
  always_comb begin
    first_ext = first_data;
    op2_ext = op2_data;
    if (first_byte) begin
      first_ext = {{8{first_data[MPR_BYTE_SIGN] & first_kind[0]}}, first_data[7:0]};
    end
    if (op2_byte) begin
      op2_ext = {{8{op2_data[MPR_BYTE_SIGN] & is_signed}}, op2_data[7:0]};
    end
  end

  // Operand values at their effective widths
  assign op1_val = s_q.op1_wide ? {s_q.op1_hi, s_q.op1_lo}
                 : {{16{s_q.op1_lo[15] & is_signed}}, s_q.op1_lo};
  assign op2_val = s_q.op2_wide ? {s_q.op2_hi, s_q.op2_lo}
                 : {{16{s_q.op2_lo[15] & is_signed}}, s_q.op2_lo};
  assign op1_s = {op1_val[31] & is_signed, op1_val};
  assign op2_s = {op2_val[31] & is_signed, op2_val};
  assign prod_full = op1_s * op2_s;
  assign prod = prod_full[63:0];

  ////////////////////////////////////////////////////////////////////
  // Accumulation and carry

  // Carry of the accumulation only, never an input
  assign sum32 = {1'b0, s_q.base[31:0]} + {1'b0, prod[31:0]};
  assign sum64 = {1'b0, s_q.base} + {1'b0, prod};

  // Result and carry per width and kind
  always_comb begin
    calc_res = prod;
    calc_carry = 1'b0;
    if (!s_q.op1_wide && !s_q.op2_wide) begin
      if (is_acc) begin
        calc_res = {{32{sum32[31] & is_signed}}, sum32[31:0]};
        calc_carry = sum32[32];
      end else if (is_signed) begin
        calc_carry = prod[MPR_SIGN32];
      end
    end else begin
      if (is_acc) begin
        calc_res = sum64[63:0];
        calc_carry = sum64[64];
      end else if (is_signed) begin
        calc_carry = prod[MPR_SIGN64];
      end
    end
    if (s_q.kind == MPR_UMUL) begin
      calc_carry = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ready timing

  // Tables chosen by operand widths
  always_comb begin
    lat_hi = MPR_LAT_N_WH;
    if (!s_q.op2_wide) begin
      lat_lo = s_q.op1_wide ? MPR_LAT_W_N : MPR_LAT_N_N;
    end else begin
      lat_lo = s_q.op1_wide ? MPR_LAT_W_WL : MPR_LAT_N_WL;
      lat_hi = s_q.op1_wide ? MPR_LAT_W_WH : MPR_LAT_N_WH;
    end
  end

  // Word ready when the low write count, and for a wide second operand also the high one, reaches the table, later one wins
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_ready
      assign ready[gi] = (s_q.cnt_lo >= lat_lo[gi])
                       && (!s_q.op2_wide || (s_q.hi_done && s_q.cnt_hi >= lat_hi[gi]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.calc = 1'b0;
    if (s_q.cnt_lo != MPR_CNT_RST) begin
      s_d.cnt_lo = s_q.cnt_lo + 4'h1;
    end
    if (s_q.cnt_hi != MPR_CNT_RST) begin
      s_d.cnt_hi = s_q.cnt_hi + 4'h1;
    end
    // First operand: address picks kind and width
    if (first_wr) begin
      if (first_high) begin
        s_d.op1_hi = first_ext;
        s_d.op1_wide = 1'b1;
      end else begin
        s_d.op1_lo = first_ext;
        s_d.op1_wide = 1'b0;
        s_d.kind = mpr_kind_t'(first_kind);
      end
    end
    // Preload of one result word
    if (res_wr) begin
      s_d.result[16 * res_wr_sel +: 16] = res_wr_data;
    end
    // Narrow second operand starts at once
    if (op2_16_wr) begin
      s_d.op2_lo = op2_ext;
      s_d.op2_wide = 1'b0;
      s_d.hi_pending = 1'b0;
      s_d.calc = 1'b1;
      s_d.base = s_q.result;
      s_d.cnt_lo = 4'h0;
    end else if (op2_low_wr) begin
      // Low half starts, high half completes
      s_d.op2_lo = op2_ext;
      s_d.op2_wide = 1'b1;
      s_d.hi_pending = 1'b1;
      s_d.hi_done = 1'b0;
      s_d.base = s_q.result;
      s_d.cnt_lo = 4'h0;
    end else if (op2_high_wr && s_q.hi_pending) begin
      s_d.op2_hi = op2_ext;
      s_d.hi_pending = 1'b0;
      s_d.hi_done = 1'b1;
      s_d.calc = 1'b1;
      s_d.cnt_hi = 4'h0;
    end
    // Store result; fractional mode never alters it
    if (s_q.calc) begin
      s_d.result = calc_res;
      s_d.carry = calc_carry;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.cnt_lo <= MPR_CNT_RST;
      s_q.cnt_hi <= MPR_CNT_RST;
      s_q.result <= MPR_RESULT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read side

  assign rif.result = s_q.result;
  assign rif.carry = s_q.carry;
  assign rif.kind = s_q.kind;
  assign rif.wide = s_q.op1_wide || s_q.op2_wide;
  assign rif.frac = fractional_enable;

  mpr_ext_unit u_ext (
    .rif(rif.view),
    .sum_extension_word(sum_extension_word)
  );

  mpr_read_view u_view (
    .core_clk(core_clk),
    .reset(reset),
    .rif(rif.view),
    .sum_extension_word(sum_extension_word),
    .rd_en(rd_en),
    .rd_sel(rd_sel),
    .rd_data(rd_data)
  );

  // Status outputs
  assign result_word_valid = ready[3:0];
  assign carry_valid = ready[MPR_CARRY_SLOT];
  assign carry_flag = s_q.carry;

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_op2_starts_calc: assert property (@(posedge core_clk) disable iff (reset)
    op2_16_wr |=> s_q.calc && s_q.cnt_lo == 4'h0)
    else $error("narrow second operand did not start");
  a_high_alone_ignored: assert property (@(posedge core_clk) disable iff (reset)
    op2_high_wr && !s_q.hi_pending && !op2_16_wr && !op2_low_wr |=> !s_q.calc)
    else $error("lone high half started an operation");
  a_umul_carry_clear: assert property (@(posedge core_clk) disable iff (reset)
    s_q.calc && s_q.kind == MPR_UMUL |=> !carry_flag)
    else $error("unsigned multiply set carry");
  a_smul_carry_sign: assert property (@(posedge core_clk) disable iff (reset)
    s_q.calc && s_q.kind == MPR_SMUL
      |=> carry_flag == ($past(rif.wide) ? s_q.result[63] : s_q.result[31]))
    else $error("signed multiply carry not sign");
  a_narrow_sign_ext: assert property (@(posedge core_clk) disable iff (reset)
    s_q.calc && is_signed && !rif.wide |=> s_q.result[63:32] == {32{s_q.result[31]}})
    else $error("signed narrow result not extended");
  a_narrow_ready_time: assert property (@(posedge core_clk) disable iff (reset)
    op2_16_wr && !s_d.op1_wide ##1 (!op2_16_wr && !op2_low_wr && !first_wr)[*4]
      |-> result_word_valid == 4'h3 && carry_valid)
    else $error("narrow words not ready at three cycles");
  a_wide_ready_order: assert property (@(posedge core_clk) disable iff (reset)
    s_q.op2_wide && result_word_valid[3] |-> s_q.hi_done && s_q.cnt_lo >= lat_lo[3])
    else $error("wide word three ready too early");
  a_frac_store_kept: assert property (@(posedge core_clk) disable iff (reset)
    $changed(fractional_enable) && !s_q.calc && !res_wr |-> s_d.result == s_q.result)
    else $error("fractional mode changed stored result");
  // Extension word, byte, carry and wide low-half arming checks
  a_umul_ext_zero: assert property (@(posedge core_clk) disable iff (reset)
    s_q.kind == MPR_UMUL |-> sum_extension_word == MPR_SUM_EXTENSION_WORD_ZERO)
    else $error("unsigned multiply extension word not zero");
  a_smul_ext_sign: assert property (@(posedge core_clk) disable iff (reset)
    !fractional_enable && s_q.kind == MPR_SMUL && !rif.wide
      |-> sum_extension_word == (s_q.result[MPR_SIGN32] ? MPR_SUM_EXTENSION_WORD_ONES : MPR_SUM_EXTENSION_WORD_ZERO))
    else $error("signed multiply extension word not sign");
  a_frac_ext_bits: assert property (@(posedge core_clk) disable iff (reset)
    fractional_enable && is_signed
      |-> sum_extension_word[15:1] == {15{s_q.carry}}
        && sum_extension_word[0] == (rif.wide ? s_q.result[MPR_SIGN64] : s_q.result[MPR_SIGN32]))
    else $error("fractional extension word wrong");
  a_signed_byte_ext: assert property (@(posedge core_clk) disable iff (reset)
    op2_16_wr && op2_byte && is_signed |=> s_q.op2_lo[15:8] == {8{s_q.op2_lo[7]}})
    else $error("signed byte operand not extended");
  a_carry_frac_kept: assert property (@(posedge core_clk) disable iff (reset)
    $changed(fractional_enable) && !s_q.calc |=> carry_flag == $past(carry_flag))
    else $error("fractional switch changed carry");
  a_low_arms_high: assert property (@(posedge core_clk) disable iff (reset)
    op2_low_wr && !op2_16_wr |=> s_q.hi_pending && !s_q.calc && s_q.cnt_lo == 4'h0)
    else $error("low half did not arm the high half");

  c_narrow_acc: cover property (@(posedge core_clk) disable iff (reset)
    s_q.calc && is_acc && !rif.wide ##1 carry_flag);
  c_wide_signed: cover property (@(posedge core_clk) disable iff (reset)
    s_q.calc && is_signed && s_q.op1_wide && s_q.op2_wide);
  c_frac_read: cover property (@(posedge core_clk) disable iff (reset)
    rd_en && fractional_enable && rd_sel == MPR_SEL_W1);
  c_lone_high: cover property (@(posedge core_clk) disable iff (reset)
    op2_high_wr && !s_q.hi_pending && !op2_low_wr);
  c_sacc_overflow: cover property (@(posedge core_clk) disable iff (reset)
    s_q.calc && s_q.kind == MPR_SACC ##1 carry_flag != s_q.result[MPR_SIGN32]);
endmodule

// ---- bench/mpr_cpu_model.sv ----
// CPU-side model that writes operands, preloads results and reads the result path
`timescale 1ns/1ps
module mpr_cpu_model
  import mpr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // First operand writes
  output logic first_wr,
  output logic [1:0] first_kind,
  output logic first_high,
  output logic first_byte,
  output logic [15:0] first_data,
  // Second operand writes
  output logic op2_16_wr,
  output logic op2_low_wr,
  output logic op2_high_wr,
  output logic op2_byte,
  output logic [15:0] op2_data,
  // Result preload and control
  output logic res_wr,
  output logic [1:0] res_wr_sel,
  output logic [15:0] res_wr_data,
  output logic fractional_enable,
  // Read port
  output logic rd_en,
  output logic [2:0] rd_sel,
  input wire logic [15:0] rd_data,
  input wire logic [3:0] result_word_valid,
  input wire logic carry_valid
);
  ////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    {first_wr, first_high, first_byte, op2_16_wr, op2_low_wr} = 5'h0;
    {op2_high_wr, op2_byte, res_wr, fractional_enable, rd_en} = 5'h0;
    {first_kind, res_wr_sel, rd_sel} = 7'h0;
    {first_data, op2_data, res_wr_data} = 48'h0;
  end

  ////////////////////////////////////////////////////////////////
  // First operand; the low write picks the kind
  task automatic wr_op1(input logic [1:0] k, input logic hi, input logic byt,
                        input logic [15:0] d);
    @(posedge core_clk);
    first_wr <= 1'b1;
    first_kind <= k;
    first_high <= hi;
    first_byte <= byt;
    first_data <= d;
    @(posedge core_clk);
    first_wr <= 1'b0;
    first_data <= ~d; // Released data lines do not keep the value
  endtask

  // Narrow second operand, starts the operation
  task automatic wr_op2(input logic byt, input logic [15:0] d);
    @(posedge core_clk);
    op2_16_wr <= 1'b1;
    op2_byte <= byt;
    op2_data <= d;
    @(posedge core_clk);
    op2_16_wr <= 1'b0;
    op2_data <= ~d;
  endtask

  // Wide second operand, low half then high half back to back
  task automatic wr_op2_wide(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge core_clk);
    op2_low_wr <= 1'b1;
    op2_byte <= 1'b0;
    op2_data <= lo;
    @(posedge core_clk);
    op2_low_wr <= 1'b0;
    op2_high_wr <= 1'b1;
    op2_data <= hi;
    @(posedge core_clk);
    op2_high_wr <= 1'b0;
    op2_data <= ~hi;
  endtask

  // Bounded wait until every word and the carry are ready
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 40 && ok !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
      ok = (result_word_valid === 4'hf) && (carry_valid === 1'b1);
    end
  endtask

  // Preload all four result words once the last operation is over
  task automatic preload(input logic [63:0] v, output logic ok);
    wait_done(ok);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      res_wr <= 1'b1;
      res_wr_sel <= 2'(i);
      res_wr_data <= v[16*i +: 16];
    end
    @(posedge core_clk);
    res_wr <= 1'b0;
    res_wr_data <= ~v[63:48];
  endtask

  // One read; data is taken the cycle after the request edge
  task automatic read(input logic [2:0] sel, output logic [15:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_sel <= sel;
    @(posedge core_clk);
    rd_en <= 1'b0;
    rd_sel <= ~sel;
    #1;
    d = rd_data;
  endtask

  // Lone high half, ignored without a pending low half
  task automatic wr_op2_high(input logic [15:0] d);
    @(posedge core_clk);
    op2_high_wr <= 1'b1;
    op2_data <= d;
    @(posedge core_clk);
    op2_high_wr <= 1'b0;
    op2_data <= ~d;
  endtask

  // Fractional control bit
  task automatic set_frac(input logic v);
    @(posedge core_clk);
    fractional_enable <= v;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking testbench for the multiplier result path
`timescale 1ns/1ps
module tb_top;
  import mpr_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic first_wr, first_high, first_byte, op2_16_wr, op2_low_wr, op2_high_wr, op2_byte;
  logic res_wr, fractional_enable, rd_en, carry_valid, carry_flag;
  logic [1:0] first_kind, res_wr_sel;
  logic [2:0] rd_sel;
  logic [3:0] result_word_valid;
  logic [15:0] first_data, op2_data, res_wr_data, rd_data;
  int err_total = 0;
  int checked = 0;
  logic [15:0] rd_w;

  ////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 core_clk = ~core_clk;

  mpr_result_path u_dut (.core_clk, .reset, .first_wr, .first_kind, .first_high, .first_byte,
    .first_data, .op2_16_wr, .op2_low_wr, .op2_high_wr, .op2_byte, .op2_data, .res_wr,
    .res_wr_sel, .res_wr_data, .fractional_enable, .rd_en, .rd_sel, .rd_data,
    .result_word_valid, .carry_valid, .carry_flag);

  mpr_cpu_model u_cpu (.core_clk, .first_wr, .first_kind, .first_high, .first_byte,
    .first_data, .op2_16_wr, .op2_low_wr, .op2_high_wr, .op2_byte, .op2_data, .res_wr,
    .res_wr_sel, .res_wr_data, .fractional_enable, .rd_en, .rd_sel, .rd_data,
    .result_word_valid, .carry_valid);

  ////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic end_of_test();
    $display("Mismatches %0d in %0d comparisons", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready flags {carry_valid, result_word_valid} k edges later
  task automatic check_ready(input int k, input logic [4:0] exp);
    repeat (k) @(posedge core_clk);
    #1;
    check("ready flags", {carry_valid, result_word_valid}, exp);
  endtask

  // Preload after the bounded completion wait
  task automatic preload(input logic [63:0] v);
    logic ok;
    u_cpu.preload(v, ok);
    check("preload wait", ok, 1'b1);
    if (ok !== 1'b1) begin
      end_of_test();
    end
  endtask

  // Wait for the result, then read every view and compare
  task automatic expect_op(input logic [63:0] r, input logic [15:0] ext, input logic cy,
                           input logic frac);
    logic [63:0] got;
    logic [63:0] sh;
    logic [15:0] w;
    logic ok;
    sh = frac ? (r << 1) : r;
    u_cpu.wait_done(ok);
    check("completion", ok, 1'b1);
    if (ok !== 1'b1) begin
      end_of_test();
    end
    for (int i = 0; i < 4; i++) begin
      u_cpu.read(3'(i), w);
      got[16*i +: 16] = w;
    end
    check("result words", got, sh);
    u_cpu.read(MPR_SEL_CLO, w);
    check("compat low", w, sh[15:0]);
    u_cpu.read(MPR_SEL_CHI, w);
    check("compat high", w, sh[31:16]);
    u_cpu.read(MPR_SEL_SUM_EXTENSION_WORD, w);
    check("sum extension", w, ext);
    check("carry", carry_flag, cy);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check("ready after reset", {carry_valid, result_word_valid}, 5'h1f);
    check("read data after reset", rd_data, 16'h0);
    // Unsigned 16x16
    u_cpu.wr_op1(MPR_UMUL, 1'b0, 1'b0, 16'h1234);
    u_cpu.wr_op2(1'b0, 16'h5678);
    expect_op(64'h1234 * 64'h5678, 16'h0000, 1'b0, 1'b0);
    // Signed byte operands, negative product
    u_cpu.wr_op1(MPR_SMUL, 1'b0, 1'b1, 16'h0080);
    u_cpu.wr_op2(1'b1, 16'h0002);
    expect_op(64'hffff_ffff_ffff_ff00, 16'hffff, 1'b1, 1'b0);
    // Unused select reads zero after a nonzero read
    u_cpu.read(3'h7, rd_w);
    check("unused select", rd_w, 16'h0);
    // Unsigned accumulate with 32-bit carry
    preload(64'h0000_0000_ffff_ffff);
    u_cpu.wr_op1(MPR_UACC, 1'b0, 1'b0, 16'h0001);
    u_cpu.wr_op2(1'b0, 16'h0001);
    expect_op(64'h0, 16'h0001, 1'b1, 1'b0);
    // Carry from the last accumulate is not added back
    u_cpu.wr_op1(MPR_UACC, 1'b0, 1'b0, 16'h0000);
    u_cpu.wr_op2(1'b0, 16'h0000);
    expect_op(64'h0, 16'h0000, 1'b0, 1'b0);
    // Signed accumulate overflow: carry differs from sign
    preload(64'h0000_0000_7fff_ffff);
    u_cpu.wr_op1(MPR_SACC, 1'b0, 1'b0, 16'h0001);
    u_cpu.wr_op2(1'b0, 16'h0001);
    expect_op(64'hffff_ffff_8000_0000, 16'hffff, 1'b0, 1'b0);
    // Signed 32x16, sign taken from the 64-bit result
    u_cpu.wr_op1(MPR_SMUL, 1'b0, 1'b0, 16'hfffe);
    u_cpu.wr_op1(MPR_SMUL, 1'b1, 1'b0, 16'hffff);
    u_cpu.wr_op2(1'b0, 16'h0003);
    expect_op(64'hffff_ffff_ffff_fffa, 16'hffff, 1'b1, 1'b0);
    // Fractional Q15 product and narrow ready timing
    u_cpu.set_frac(1'b1);
    u_cpu.wr_op1(MPR_SMUL, 1'b0, 1'b0, 16'h4000);
    u_cpu.wr_op2(1'b0, 16'h4000);
    check_ready(2, 5'h00);
    check_ready(1, 5'h13);
    check_ready(1, 5'h1f);
    expect_op(64'h1000_0000, 16'h0000, 1'b0, 1'b1);
    // Fractional unsigned 32x32 and wide ready timing
    u_cpu.wr_op1(MPR_UMUL, 1'b0, 1'b0, 16'h1234);
    u_cpu.wr_op1(MPR_UMUL, 1'b1, 1'b0, 16'h1234);
    u_cpu.wr_op2_wide(16'h5678, 16'h5678);
    check_ready(6, 5'h01);
    check_ready(1, 5'h03);
    check_ready(2, 5'h07);
    check_ready(1, 5'h1f);
    expect_op(64'h1234_1234 * 64'h5678_5678, 16'h0000, 1'b0, 1'b1);
    // Fractional signed 32x32 negative
    u_cpu.wr_op1(MPR_SMUL, 1'b0, 1'b0, 16'hfffe);
    u_cpu.wr_op1(MPR_SMUL, 1'b1, 1'b0, 16'hffff);
    u_cpu.wr_op2_wide(16'h0003, 16'h0000);
    expect_op(64'hffff_ffff_ffff_fffa, 16'hffff, 1'b1, 1'b1);
    // Lone high half is ignored, store kept
    u_cpu.wr_op2_high(16'h0001);
    expect_op(64'hffff_ffff_ffff_fffa, 16'hffff, 1'b1, 1'b1);
    // Store unchanged once fractional reads are switched off
    u_cpu.set_frac(1'b0);
    expect_op(64'hffff_ffff_ffff_fffa, 16'hffff, 1'b1, 1'b0);
    end_of_test();
  end
endmodule
